// >>> logic/crd_defines.vh
`ifndef CRD_DEFINES_VH
`define CRD_DEFINES_VH

// sizes of the generic clock controller
`define CRD_NGEN        12
`define CRD_NCH         8
`define CRD_GIDX_W      4
`define CRD_CIDX_W      3
`define CRD_SRC_W       4
`define CRD_DIV_W       8
`define CRD_LF_W        2

// oscillator frequency codes
`define CRD_FREQ_W      2
`define CRD_FREQ_48M    2'h0

// source code of the main loop oscillator (arbitrary)
`define CRD_SRC_MLO     4'h6
`define CRD_SRC_NONE    4'h0
`define CRD_GEN_MAIN    4'h0

// reset values
`define CRD_DIV_ONE     8'h01
`define CRD_LF_RST      2'h0
`define CRD_GEN_RST     4'h0

// peripheral clock edges needed to carry status into the cpu domain
`define CRD_SYNC_STAGES 2

`endif

// >>> logic/crd_periph_sync.v
`include "crd_defines.vh"

module crd_periph_sync
(
	input  wire                   i_mclk,   // main clock
	input  wire                   i_rst_n,  // synchronised reset
	input  wire                   i_per_clk, // peripheral clock pin
	input  wire [`CRD_NCH-1:0]    i_state,  // peripheral side state
	output wire [`CRD_NCH-1:0]    o_state   // state seen by cpu domain
);

	reg        per_s1_q;
	reg        per_s2_q;
	reg        per_s3_q;
	wire       tick;
	reg  [`CRD_NCH*`CRD_SYNC_STAGES-1:0] pipe_q;

	// pin synchroniser; the second and third stages are looked at
	always @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			per_s1_q <= 1'b0;
			per_s2_q <= 1'b0;
			per_s3_q <= 1'b0;
		end
		else
		begin
			per_s1_q <= i_per_clk;
			per_s2_q <= per_s1_q;
			per_s3_q <= per_s2_q;
		end
	end

	// one tick per rising peripheral clock edge
	assign tick = per_s2_q & ~per_s3_q;

	// stages advance only on peripheral edges, so delay scales with it
	genvar c;
	generate
		for (c = 0; c < `CRD_NCH; c = c + 1)
		begin : g_ch
			always @(posedge i_mclk or negedge i_rst_n)
			begin
				if (!i_rst_n)
					pipe_q[c*`CRD_SYNC_STAGES +: `CRD_SYNC_STAGES] <=
						{`CRD_SYNC_STAGES{1'b0}};
				else if (tick)
					pipe_q[c*`CRD_SYNC_STAGES +: `CRD_SYNC_STAGES] <=
						{pipe_q[c*`CRD_SYNC_STAGES +: `CRD_SYNC_STAGES-1],
						 i_state[c]};
			end
			assign o_state[c] =
				pipe_q[c*`CRD_SYNC_STAGES + `CRD_SYNC_STAGES - 1];
		end
	endgenerate

endmodule // crd_periph_sync

// >>> logic/crd_clock_reset_defaults.v
// Summary of operation
// - Any reset turns the main loop oscillator on at its 48 MHz setting.
// - Any reset makes generator 0 run from the main loop oscillator.
// - Any reset sets the processor and bus clock dividers to one.
// - A power-on reset also returns the 32 kHz sources to reset state.
// - A power-on reset disables every generator except generator 0.
// - A power-on reset disables every peripheral clock channel.
// - A user reset restores the controller except the 32 kHz sources and write-locked channels.
// - Peripheral status reaches the cpu side after peripheral clock edges.
`include "crd_defines.vh"

module crd_clock_reset_defaults
(
	input  wire                     i_mclk,     // 10 MHz main clock
	input  wire                     i_arst_n,   // async reset, low
	input  wire                     i_por_req,  // power-on reset cause
	input  wire                     i_user_req, // user reset cause
	input  wire                     i_sys_req,  // any other reset cause
	input  wire                     i_per_clk,  // peripheral clock pin
	input  wire                     i_osc_we,   // oscillator write
	input  wire                     i_osc_en,   // oscillator enable
	input  wire [`CRD_FREQ_W-1:0]   i_osc_freq, // oscillator freq code
	input  wire                     i_lf_we,    // 32k source write
	input  wire [`CRD_LF_W-1:0]     i_lf_en,    // 32k source enables
	input  wire                     i_div_we,   // divider write
	input  wire [`CRD_DIV_W-1:0]    i_cpu_div,  // cpu divide factor
	input  wire [`CRD_DIV_W-1:0]    i_bus_div,  // bus divide factor
	input  wire                     i_gen_we,   // generator write
	input  wire [`CRD_GIDX_W-1:0]   i_gen_idx,  // generator index
	input  wire                     i_gen_en,   // generator enable
	input  wire [`CRD_SRC_W-1:0]    i_gen_src,  // generator source
	input  wire                     i_ch_we,    // channel write
	input  wire [`CRD_CIDX_W-1:0]   i_ch_idx,   // channel index
	input  wire                     i_ch_en,    // channel enable
	input  wire [`CRD_GIDX_W-1:0]   i_ch_gen,   // channel generator
	input  wire                     i_ch_lock,  // channel write lock
	output reg                      o_osc_en,   // oscillator running
	output reg  [`CRD_FREQ_W-1:0]   o_osc_freq, // oscillator freq code
	output reg  [`CRD_LF_W-1:0]     o_lf_en,    // 32k source enables
	output reg  [`CRD_DIV_W-1:0]    o_cpu_div,  // cpu divide factor
	output reg  [`CRD_DIV_W-1:0]    o_bus_div,  // bus divide factor
	output wire [`CRD_NGEN-1:0]     o_gen_en,   // generator enables
	output wire [`CRD_NGEN*`CRD_SRC_W-1:0] o_gen_src, // generator sources
	output wire [`CRD_NCH-1:0]      o_ch_en,    // channel enables
	output wire [`CRD_NCH*`CRD_GIDX_W-1:0] o_ch_gen, // channel generators
	output wire [`CRD_NCH-1:0]      o_ch_lock,  // channel write locks
	output wire [`CRD_NCH-1:0]      o_ch_sync   // channel state, cpu side
);

	reg                      rst_s1_q;
	reg                      rst_n_q;
	wire                     any_req;
	wire                     generic_clock_controller_init;
	reg  [`CRD_NGEN-1:0]     gen_en_q;
	reg  [`CRD_SRC_W-1:0]    gen_src_q [0:`CRD_NGEN-1];
	reg  [`CRD_NCH-1:0]      ch_en_q;
	reg  [`CRD_NCH-1:0]      ch_lock_q;
	reg  [`CRD_GIDX_W-1:0]   ch_gen_q [0:`CRD_NCH-1];

	// reset release through two flops
	always @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// causes come from logic on this clock, so no synchroniser
	assign any_req   = i_por_req | i_user_req | i_sys_req;
	assign generic_clock_controller_init = i_por_req | i_user_req;

	// oscillator, 32k sources and system dividers
	always @(posedge i_mclk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			o_osc_en   <= 1'b1;
			o_osc_freq <= `CRD_FREQ_48M;
			o_lf_en    <= `CRD_LF_RST;
			o_cpu_div  <= `CRD_DIV_ONE;
			o_bus_div  <= `CRD_DIV_ONE;
		end
		else
		begin
			if (any_req)
			begin
				o_osc_en   <= 1'b1;
				o_osc_freq <= `CRD_FREQ_48M;
				o_cpu_div  <= `CRD_DIV_ONE;
				o_bus_div  <= `CRD_DIV_ONE;
			end
			else
			begin
				if (i_osc_we)
				begin
					o_osc_en   <= i_osc_en;
					o_osc_freq <= i_osc_freq;
				end
				if (i_div_we)
				begin
					o_cpu_div <= i_cpu_div;
					o_bus_div <= i_bus_div;
				end
			end
			// 32k sources survive everything but power-on
			if (i_por_req)
				o_lf_en <= `CRD_LF_RST;
			else if (i_lf_we && !any_req)
				o_lf_en <= i_lf_en;
		end
	end

	// generator 0 always comes back running from the oscillator
	always @(posedge i_mclk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			gen_en_q[0]  <= 1'b1;
			gen_src_q[0] <= `CRD_SRC_MLO;
		end
		else if (any_req)
		begin
			gen_en_q[0]  <= 1'b1;
			gen_src_q[0] <= `CRD_SRC_MLO;
		end
		else if (i_gen_we && i_gen_idx == `CRD_GEN_MAIN)
		begin
			gen_en_q[0]  <= i_gen_en;
			gen_src_q[0] <= i_gen_src;
		end
	end

	// remaining generators; other reset causes leave them alone
	genvar g;
	generate
		for (g = 1; g < `CRD_NGEN; g = g + 1)
		begin : g_gen
			// index held at port width so the compare keeps its size
			localparam [`CRD_GIDX_W-1:0] gen_id = g;
			always @(posedge i_mclk or negedge rst_n_q)
			begin
				if (!rst_n_q)
				begin
					gen_en_q[g]  <= 1'b0;
					gen_src_q[g] <= `CRD_SRC_NONE;
				end
				else if (generic_clock_controller_init)
				begin
					gen_en_q[g]  <= 1'b0;
					gen_src_q[g] <= `CRD_SRC_NONE;
				end
				else if (!any_req && i_gen_we &&
					 i_gen_idx == gen_id)
				begin
					gen_en_q[g]  <= i_gen_en;
					gen_src_q[g] <= i_gen_src;
				end
			end
		end
	endgenerate

	// peripheral channels; a set lock blocks writes and user reset
	genvar c;
	generate
		for (c = 0; c < `CRD_NCH; c = c + 1)
		begin : g_ch
			// index held at port width so the compare keeps its size
			localparam [`CRD_CIDX_W-1:0] ch_id = c;
			always @(posedge i_mclk or negedge rst_n_q)
			begin
				if (!rst_n_q)
				begin
					ch_en_q[c]   <= 1'b0;
					ch_lock_q[c] <= 1'b0;
					ch_gen_q[c]  <= `CRD_GEN_RST;
				end
				else if (i_por_req)
				begin
					ch_en_q[c]   <= 1'b0;
					ch_lock_q[c] <= 1'b0;
					ch_gen_q[c]  <= `CRD_GEN_RST;
				end
				else if (i_user_req && !ch_lock_q[c])
				begin
					ch_en_q[c]   <= 1'b0;
					ch_gen_q[c]  <= `CRD_GEN_RST;
				end
				else if (!any_req && !ch_lock_q[c] && i_ch_we &&
					 i_ch_idx == ch_id)
				begin
					ch_en_q[c]   <= i_ch_en;
					ch_lock_q[c] <= i_ch_lock;
					ch_gen_q[c]  <= i_ch_gen;
				end
			end
			assign o_ch_gen[c*`CRD_GIDX_W +: `CRD_GIDX_W] = ch_gen_q[c];
		end
	endgenerate

	// flatten generator sources onto the output bus
	genvar s;
	generate
		for (s = 0; s < `CRD_NGEN; s = s + 1)
		begin : g_src
			assign o_gen_src[s*`CRD_SRC_W +: `CRD_SRC_W] = gen_src_q[s];
		end
	endgenerate

	assign o_gen_en  = gen_en_q;
	assign o_ch_en   = ch_en_q;
	assign o_ch_lock = ch_lock_q;

	// slow peripheral clock means slow status, by design
	crd_periph_sync u_sync
	(
		.i_mclk    (i_mclk),
		.i_rst_n   (rst_n_q),
		.i_per_clk (i_per_clk),
		.i_state   (ch_en_q),
		.o_state   (o_ch_sync)
	);

endmodule // crd_clock_reset_defaults

// >>> sim/crd_props.sv
`include "crd_defines.vh"
module crd_props
(
	input logic        i_mclk,     // clock
	input logic        i_arst_n,   // reset, low
	input logic        i_por_req,  // por cause
	input logic        i_user_req, // user cause
	input logic        i_sys_req,  // other cause
	input logic        i_per_clk,  // periph clock
	input logic        o_osc_en,   // osc on
	input logic [1:0]  o_osc_freq, // freq code
	input logic [1:0]  o_lf_en,    // 32k enables
	input logic [7:0]  o_cpu_div,  // cpu div
	input logic [7:0]  o_bus_div,  // bus div
	input logic [11:0] o_gen_en,   // gen enables
	input logic [47:0] o_gen_src,  // gen sources
	input logic [7:0]  o_ch_en,    // ch enables
	input logic [7:0]  o_ch_lock,  // ch locks
	input logic [7:0]  o_ch_sync   // ch sync
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_mclk);
	endclocking
	default disable iff (!i_arst_n);
	// any cause sets the common part
	wire any_cause = i_por_req | i_user_req | i_sys_req;
	sequence s_user; i_user_req && !i_por_req; endsequence
	property p_osc; any_cause |=> o_osc_en && o_osc_freq == 2'h0; endproperty
	a_osc: assert property (p_osc) else $error("osc default lost");
	property p_gen0; any_cause |=> o_gen_en[0] && o_gen_src[3:0] == 4'h6;
	endproperty
	a_gen0: assert property (p_gen0) else $error("gen0 wrong");
	property p_div; any_cause |=> o_cpu_div == 8'h01 && o_bus_div == 8'h01;
	endproperty
	a_div: assert property (p_div) else $error("divider wrong");
	property p_lf; i_por_req |=> o_lf_en == 2'h0; endproperty
	a_lf: assert property (p_lf) else $error("32k not reset");
	property p_gens; i_por_req |=> o_gen_en == 12'h001; endproperty
	a_gens: assert property (p_gens) else $error("gens on");
	property p_chan; i_por_req |=> o_ch_en == 8'h00 && o_ch_lock == 8'h00;
	endproperty
	a_chan: assert property (p_chan) else $error("channel on");
	// locked channels survive, the rest are cleared
	property p_lock; s_user |=> o_ch_lock == $past(o_ch_lock)
		&& (o_ch_en & ~o_ch_lock) == 8'h00
		&& (o_ch_en & o_ch_lock) == ($past(o_ch_en) & o_ch_lock);
	endproperty
	a_lock: assert property (p_lock) else $error("lock lost");
	// no peripheral ticks, so nothing may cross
	property p_sync; !i_per_clk [*8] |-> $stable(o_ch_sync); endproperty
	a_sync: assert property (p_sync) else $error("sync moved");
endmodule // crd_props

bind crd_clock_reset_defaults crd_props u_props
(
	.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_por_req(i_por_req),
	.i_user_req(i_user_req), .i_sys_req(i_sys_req), .i_per_clk(i_per_clk),
	.o_osc_en(o_osc_en), .o_osc_freq(o_osc_freq), .o_lf_en(o_lf_en),
	.o_cpu_div(o_cpu_div), .o_bus_div(o_bus_div), .o_gen_en(o_gen_en),
	.o_gen_src(o_gen_src), .o_ch_en(o_ch_en), .o_ch_lock(o_ch_lock),
	.o_ch_sync(o_ch_sync)
);

// >>> sim/crd_rst_model.sv
module crd_rst_model
(
	output logic o_por_req,  // por cause
	output logic o_user_req, // user cause
	output logic o_sys_req,  // other cause
	input  logic i_mclk      // clock
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {o_por_req, o_user_req, o_sys_req} = 3'h0;
	// one distinct cause per request, one clock long
	task fire(input logic [2:0] cause);
		@(posedge i_mclk) #1;
		{o_por_req, o_user_req, o_sys_req} = cause;
		@(posedge i_mclk) #1;
		{o_por_req, o_user_req, o_sys_req} = 3'h0;
	endtask
endmodule // crd_rst_model

// >>> sim/crd_clock_reset_defaults_bench.sv
module crd_clock_reset_defaults_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, arst_n = 0, per = 0, por, usr, sys;
	logic osc_we = 0, osc_en = 0, lf_we = 0, div_we = 0, gen_we = 0;
	logic gen_en = 0, ch_we = 0, ch_en = 0, ch_lock = 0;
	logic [1:0] osc_f = 0, lf_en = 0;
	logic [7:0] cdiv = 0, bdiv = 0;
	logic [3:0] gen_idx = 0, gen_src = 0, ch_gen = 0;
	logic [2:0] ch_idx = 0;
	logic osc_q;
	logic [1:0] oscf_q, lf_q;
	logic [7:0] cdiv_q, bdiv_q, che_q, chl_q, sync_q;
	logic [11:0] gen_q;
	logic [47:0] src_q;
	logic [31:0] chg_q;
	int failures = 0, n_checks = 0, k;
	always #50 clk = ~clk;
	crd_rst_model rm (.i_mclk(clk), .o_por_req(por), .o_user_req(usr),
		.o_sys_req(sys));
	crd_clock_reset_defaults DUT (.i_mclk(clk), .i_arst_n(arst_n),
		.i_por_req(por), .i_user_req(usr), .i_sys_req(sys), .i_per_clk(per),
		.i_osc_we(osc_we), .i_osc_en(osc_en), .i_osc_freq(osc_f),
		.i_lf_we(lf_we), .i_lf_en(lf_en), .i_div_we(div_we),
		.i_cpu_div(cdiv), .i_bus_div(bdiv), .i_gen_we(gen_we),
		.i_gen_idx(gen_idx), .i_gen_en(gen_en), .i_gen_src(gen_src),
		.i_ch_we(ch_we), .i_ch_idx(ch_idx), .i_ch_en(ch_en),
		.i_ch_gen(ch_gen), .i_ch_lock(ch_lock), .o_osc_en(osc_q),
		.o_osc_freq(oscf_q), .o_lf_en(lf_q), .o_cpu_div(cdiv_q),
		.o_bus_div(bdiv_q), .o_gen_en(gen_q), .o_gen_src(src_q),
		.o_ch_en(che_q), .o_ch_gen(chg_q), .o_ch_lock(chl_q),
		.o_ch_sync(sync_q));
	task cyc;
		@(posedge clk) #1;
	endtask
	task chk(input string what, input logic [63:0] seen, exp);
		n_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task end_of_test;
		$display("checks %0d, failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// move every group off its default, ch2 open and ch5 locked
	task setup;
		cyc;
		{osc_we, osc_en, osc_f, lf_we, lf_en} = {4'h9, 3'h7};
		{div_we, cdiv, bdiv} = {1'b1, 8'h04, 8'h02};
		{gen_we, gen_idx, gen_en, gen_src} = {5'h13, 5'h12};
		{ch_we, ch_idx, ch_en, ch_gen, ch_lock} = {4'ha, 1'b1, 4'h3, 1'b0};
		cyc;
		{osc_we, lf_we, div_we, gen_we} = 4'h0;
		{ch_idx, ch_gen, ch_lock} = {3'h5, 4'h4, 1'b1};
		cyc;
		ch_we = 0;
		chk("setup", {osc_q, che_q}, 9'h024);
		chk("setup", {oscf_q, lf_q, cdiv_q, bdiv_q, gen_q}, 32'h7040_2009);
	endtask
	task common;
		chk("osc", {osc_q, oscf_q}, 3'h4);
		chk("gen0", {gen_q[0], src_q[3:0]}, 5'h16);
		chk("div", {cdiv_q, bdiv_q}, 16'h0101);
	endtask
	task t_sys;
		setup;
		rm.fire(3'h1);
		common;
		chk("lf kept", lf_q, 2'h3);
		chk("gens kept", gen_q, 12'h009);
		$display("other reset done");
	endtask
	task t_user;
		setup;
		rm.fire(3'h2);
		common;
		chk("locked ch", {che_q, chl_q}, 16'h2020);
		chk("locked gen", {chg_q[23:20], chg_q[11:8]}, 8'h40);
		chk("user gens", {gen_q, lf_q}, 14'h0007);
		$display("user reset done");
	endtask
	task t_por;
		setup;
		rm.fire(3'h4);
		common;
		chk("lf", lf_q, 2'h0);
		chk("gens", {gen_q, src_q}, 60'h001_0000_0000_0006);
		chk("chans", {che_q, chl_q}, 16'h0000);
		$display("power-on reset done");
	endtask
	task tick;
		per = 1;
		repeat (4) cyc;
		per = 0;
		repeat (4) cyc;
	endtask
	// status crosses only on peripheral clock edges
	task t_sync;
		cyc;
		{ch_we, ch_idx, ch_en} = {1'b1, 3'h1, 1'b1};
		cyc;
		ch_we = 0;
		repeat (10) cyc;
		chk("no tick", sync_q, 8'h00);
		tick;
		chk("one tick", sync_q, 8'h00);
		tick;
		for (k = 0; k < 20 && sync_q !== 8'h02; k++)
			cyc;
		chk("two ticks", sync_q, 8'h02);
		$display("sync done");
	endtask
	initial
	begin
		repeat (8) @(posedge clk);
		#1 arst_n = 1;
		repeat (3) cyc;
		t_sys;
		t_user;
		t_por;
		t_sync;
		end_of_test;
	end
endmodule // crd_clock_reset_defaults_bench
